// ### design/pcfe_pkg.sv
package pcfe_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] POWER_CONTROL_ADDR     = 8'h06;
  localparam logic [7:0] RESUME_FLAGS_ADDR      = 8'h07;
  localparam logic [7:0] UNLOCK_KEY_ADDR        = 8'h10;
  localparam logic [7:0] BUCK_RAIL_ENABLES_ADDR = 8'h11;

  // Reset values and writable masks
  localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
  localparam logic [7:0] RESUME_FLAGS_RESET  = 8'h00;
  localparam logic [7:0] BUCK_ENABLES_RESET  = 8'h00;
  localparam logic [7:0] POWER_CONTROL_MASK  = 8'h03;
  localparam logic [7:0] BUCK_ENABLES_MASK   = 8'h3F;
  localparam logic [7:0] ZERO_BYTE           = 8'h00;

  // Field positions
  localparam int CTRL_SHUTDOWN_EN_BIT = 1;
  localparam int CTRL_TRIGGER_BIT     = 0;
  localparam int BUCK6_BIT            = 5;
  localparam int BUCK5_BIT            = 4;
  localparam int SEAL_STATUS_BIT      = 7;

  // Unlock key value accepted by the device (arbitrary default)
  localparam logic [7:0] UNLOCK_KEY_DEFAULT = 8'h5A;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcfe_req_t;

  typedef struct packed {
    logic [3:0] buck_on;
    logic       valid;
  } pcfe_seq_t;

  typedef enum logic [1:0] {
    PCFE_ON,
    PCFE_SUSPEND,
    PCFE_OFF
  } pcfe_pwr_t;

endpackage

// ### design/pcfe_regs.sv
// Operation
// - Control resets zero; bits 7-2 read zero, ignore writes; bits 1-0 writable.
// - Shutdown enable low: power-fail output ignored, power state kept.
// - Shutdown enable high and power-fail low: all rails off, enter off.
// - Writing 1 to trigger starts measurement; device self-clears; writing 0 does nothing.
// - Flag register resets zero; bits hold gen outs 3-1, linreg, bucks 4-1.
// - On suspend wake, flag set for each output kept enabled.
// - Flags cleared on power-up from off, or when output disabled in suspend.
// - Unlock key write must precede protected access; key resets zero.
// - Unlock key also serves seal break and default programming.
// - Unlock key register always reads zero.
// - Rail enables protected, reset zero, bits 7-6 read zero, 5-0 bucks 6-1.
// - Buck 6 disable refused unless seal status is zero.
// - Buck 5 sequencer-updated (here the sequencer drives bucks 1-4 only); its disable applies only while seal is zero.
// - Sequencer overwrites buck 1-4 enables on every power-up and power-down.
// - Seal status reads 0 while intact, 1 once broken.
// - Coin-cell level valid only after a measurement trigger.
module pcfe_regs (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  // Register access from the serial interface
  input  wire pcfe_pkg::pcfe_req_t req,
  output logic [7:0]              rdata,
  // Key and seal
  input  wire logic [7:0]         unlock_key_value,
  input  wire logic               factory_seal_status,
  output logic                    key_written,
  // Power state and sequencer
  input  wire logic               power_fail_output_n,
  input  wire pcfe_pkg::pcfe_seq_t seq,
  input  wire logic               power_up_from_off,
  input  wire logic               wake_from_suspend,
  input  wire logic [7:0]         suspend_kept,
  // Coin cell
  input  wire logic               coin_cell_done,
  input  wire logic [1:0]         coin_cell_raw,
  output logic                    coin_cell_measure_trigger,
  output logic [1:0]              coin_cell_level,
  output logic                    coin_cell_level_valid,
  // Rail outputs
  output logic [5:0]              buck_on,
  output logic                    shutdown_req
);

  // ****************************************
  // State
  // ****************************************
  logic [1:0] ctrl_reg, ctrl_next;
  logic [7:0] flags_reg, flags_next;
  logic [5:0] buck_reg, buck_next;
  logic       unlocked_reg, unlocked_next;
  logic [1:0] level_reg, level_next;
  logic       level_valid_reg, level_valid_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       meas_reg, meas_next;
  pcfe_pkg::pcfe_pwr_t pwr_reg, pwr_next;

  // Address decode used by several paths
  function automatic logic hit(input pcfe_pkg::pcfe_req_t r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction

  logic ctrl_wr, buck_wr, key_wr;
  assign ctrl_wr = hit(req, pcfe_pkg::POWER_CONTROL_ADDR);
  assign buck_wr = hit(req, pcfe_pkg::BUCK_RAIL_ENABLES_ADDR);
  assign key_wr  = hit(req, pcfe_pkg::UNLOCK_KEY_ADDR);

  // Power-fail trip only counts while shutdown is enabled
  logic pf_trip;
  assign pf_trip = ctrl_reg[pcfe_pkg::CTRL_SHUTDOWN_EN_BIT] && !power_fail_output_n;

  // ****************************************
  // Control register
  // ****************************************
  // Only bits 1-0 take data; a written 1 on the trigger lasts one cycle
  always_comb begin
    ctrl_next                             = ctrl_reg;
    ctrl_next[pcfe_pkg::CTRL_TRIGGER_BIT] = 1'b0;
    if (ctrl_wr) begin
      ctrl_next = req.wdata[1:0];
    end
  end

  // Control register storage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= pcfe_pkg::POWER_CONTROL_RESET[1:0];
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ****************************************
  // Unlock key
  // ****************************************
  // Unlock lasts only until the next write of any register
  always_comb begin
    unlocked_next = unlocked_reg;
    if (req.wr) begin
      unlocked_next = key_wr && (req.wdata == unlock_key_value);
    end
  end

  // Unlock flag storage; the key value itself is never kept
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      unlocked_reg <= 1'b0;
    end else begin
      unlocked_reg <= unlocked_next;
    end
  end

  // ****************************************
  // Rail enables
  // ****************************************
  // Host write first, then the sequencer, then a power-fail shutdown on top
  always_comb begin
    logic [5:0] wv;
    wv        = '0;
    buck_next = buck_reg;
    if (buck_wr && unlocked_reg) begin
      wv = req.wdata[5:0];
      // A broken seal keeps bucks 6 and 5 from being cleared
      if (factory_seal_status) begin
        wv[pcfe_pkg::BUCK6_BIT] = wv[pcfe_pkg::BUCK6_BIT] | buck_reg[pcfe_pkg::BUCK6_BIT];
        wv[pcfe_pkg::BUCK5_BIT] = wv[pcfe_pkg::BUCK5_BIT] | buck_reg[pcfe_pkg::BUCK5_BIT];
      end
      buck_next = wv;
    end
    // Sequencer owns bucks 1-4 on power transitions
    if (seq.valid) begin
      buck_next[3:0] = seq.buck_on;
    end
    // Power-fail shutdown drops every rail
    if (pf_trip) begin
      buck_next = '0;
    end
  end

  // Rail enable storage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      buck_reg <= pcfe_pkg::BUCK_ENABLES_RESET[5:0];
    end else begin
      buck_reg <= buck_next;
    end
  end

  // ****************************************
  // Power state and resume flags
  // ****************************************
  // Power-up from off clears every flag; a wake loads the kept-on pattern
  always_comb begin
    flags_next = flags_reg;
    pwr_next   = pwr_reg;
    if (power_up_from_off) begin
      flags_next = pcfe_pkg::RESUME_FLAGS_RESET;
      pwr_next   = pcfe_pkg::PCFE_ON;
    end else if (wake_from_suspend) begin
      flags_next = suspend_kept;
      pwr_next   = pcfe_pkg::PCFE_ON;
    end
    // Power-fail level is ignored unless shutdown is enabled
    if (pf_trip) begin
      pwr_next = pcfe_pkg::PCFE_OFF;
    end
  end

  // Flag and power state storage; reset leaves the device off
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= pcfe_pkg::RESUME_FLAGS_RESET;
      pwr_reg   <= pcfe_pkg::PCFE_OFF;
    end else begin
      flags_reg <= flags_next;
      pwr_reg   <= pwr_next;
    end
  end

  // ****************************************
  // Coin-cell result
  // ****************************************
  // A result is taken only for a measurement that the host started
  always_comb begin
    meas_next        = meas_reg;
    level_next       = level_reg;
    level_valid_next = level_valid_reg;
    if (ctrl_reg[pcfe_pkg::CTRL_TRIGGER_BIT]) begin
      meas_next = 1'b1;
    end else if (coin_cell_done && meas_reg) begin
      meas_next        = 1'b0;
      level_next       = coin_cell_raw;
      level_valid_next = 1'b1;
    end
  end

  // Coin-cell storage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meas_reg        <= 1'b0;
      level_reg       <= 2'h0;
      level_valid_reg <= 1'b0;
    end else begin
      meas_reg        <= meas_next;
      level_reg       <= level_next;
      level_valid_reg <= level_valid_next;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Read data stands one cycle after the read and is zero otherwise
  always_comb begin
    rdata_next = pcfe_pkg::ZERO_BYTE;
    if (req.rd) begin
      case (req.addr)
        pcfe_pkg::POWER_CONTROL_ADDR:     rdata_next = {6'h00, ctrl_reg};
        pcfe_pkg::RESUME_FLAGS_ADDR:      rdata_next = flags_reg;
        pcfe_pkg::UNLOCK_KEY_ADDR:        rdata_next = pcfe_pkg::ZERO_BYTE;
        pcfe_pkg::BUCK_RAIL_ENABLES_ADDR: rdata_next = {2'h0, buck_reg};
        default:                          rdata_next = pcfe_pkg::ZERO_BYTE;
      endcase
    end
  end

  // Read data storage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= pcfe_pkg::ZERO_BYTE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Outputs
  assign rdata                     = rdata_reg;
  assign key_written               = unlocked_reg;
  assign coin_cell_measure_trigger = ctrl_reg[pcfe_pkg::CTRL_TRIGGER_BIT];
  assign coin_cell_level           = level_reg;
  assign coin_cell_level_valid     = level_valid_reg;
  assign buck_on                   = buck_reg;
  assign shutdown_req              = (pwr_reg == pcfe_pkg::PCFE_OFF);

  // ****************************************
  // Assertions
  // ****************************************
  property p_trigger_clears;
    @(posedge ref_clk) disable iff (!rst_n)
    coin_cell_measure_trigger && !ctrl_wr |=> !coin_cell_measure_trigger;
  endproperty
  a_trigger_clears: assert property (p_trigger_clears) else $error("trigger did not self clear");

  property p_key_reads_zero;
    @(posedge ref_clk) disable iff (!rst_n)
    req.rd && req.addr == pcfe_pkg::UNLOCK_KEY_ADDR |=> rdata == 8'h00;
  endproperty
  a_key_reads_zero: assert property (p_key_reads_zero) else $error("key read not zero");

  property p_ctrl_read;
    @(posedge ref_clk) disable iff (!rst_n)
    req.rd && req.addr == pcfe_pkg::POWER_CONTROL_ADDR |=> rdata[7:2] == 6'h00;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control reserved bits set");

  property p_locked_write;
    @(posedge ref_clk) disable iff (!rst_n)
    buck_wr && !unlocked_reg && !seq.valid && power_fail_output_n |=> $stable(buck_on);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked write changed enables");

  property p_buck6_keep;
    @(posedge ref_clk) disable iff (!rst_n)
    factory_seal_status && buck_on[5] && power_fail_output_n |=> buck_on[5];
  endproperty
  a_buck6_keep: assert property (p_buck6_keep) else $error("buck6 disabled with seal broken");

  property p_buck5_keep;
    @(posedge ref_clk) disable iff (!rst_n)
    factory_seal_status && buck_on[4] && power_fail_output_n |=> buck_on[4];
  endproperty
  a_buck5_keep: assert property (p_buck5_keep) else $error("buck5 disabled with seal broken");

  property p_pf_shutdown;
    @(posedge ref_clk) disable iff (!rst_n)
    ctrl_reg[1] && !power_fail_output_n |=> buck_on == 6'h00 && shutdown_req;
  endproperty
  a_pf_shutdown: assert property (p_pf_shutdown) else $error("power fail did not shut down");

  property p_pf_ignored;
    @(posedge ref_clk) disable iff (!rst_n)
    !ctrl_reg[1] && !shutdown_req && !power_up_from_off |=> !shutdown_req;
  endproperty
  a_pf_ignored: assert property (p_pf_ignored) else $error("power fail acted while disabled");

  property p_seq_overwrite;
    @(posedge ref_clk) disable iff (!rst_n)
    seq.valid && power_fail_output_n |=> buck_on[3:0] == $past(seq.buck_on);
  endproperty
  a_seq_overwrite: assert property (p_seq_overwrite) else $error("sequencer overwrite lost");

  property p_wake_flags;
    @(posedge ref_clk) disable iff (!rst_n)
    wake_from_suspend && !power_up_from_off |=> flags_reg == $past(suspend_kept);
  endproperty
  a_wake_flags: assert property (p_wake_flags) else $error("resume flags wrong");

  property p_flags_clear;
    @(posedge ref_clk) disable iff (!rst_n)
    power_up_from_off |=> flags_reg == pcfe_pkg::RESUME_FLAGS_RESET;
  endproperty
  a_flags_clear: assert property (p_flags_clear) else $error("flags not cleared at power up");

  property p_flag_read;
    @(posedge ref_clk) disable iff (!rst_n)
    req.rd && req.addr == pcfe_pkg::RESUME_FLAGS_ADDR |=> rdata == $past(flags_reg);
  endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag read mismatch");

  property p_enable_read;
    @(posedge ref_clk) disable iff (!rst_n)
    req.rd && req.addr == pcfe_pkg::BUCK_RAIL_ENABLES_ADDR |=> rdata[7:6] == 2'h0;
  endproperty
  a_enable_read: assert property (p_enable_read) else $error("enable reserved bits set");

  property p_key_drop;
    @(posedge ref_clk) disable iff (!rst_n)
    req.wr && !key_wr |=> !key_written;
  endproperty
  a_key_drop: assert property (p_key_drop) else $error("unlock survived another write");

  property p_level_needs_trigger;
    @(posedge ref_clk) disable iff (!rst_n)
    !coin_cell_level_valid && !meas_reg |=> !coin_cell_level_valid;
  endproperty
  a_level_needs_trigger: assert property (p_level_needs_trigger) else $error("level valid without trigger");

  // Main scenarios reached
  c_unlock_write: cover property (@(posedge ref_clk) disable iff (!rst_n) unlocked_reg && buck_wr);
  c_trigger: cover property (@(posedge ref_clk) disable iff (!rst_n) coin_cell_measure_trigger);
  c_shutdown: cover property (@(posedge ref_clk) disable iff (!rst_n) ctrl_reg[1] && !power_fail_output_n);
  c_wake: cover property (@(posedge ref_clk) disable iff (!rst_n) wake_from_suspend);
  c_coin_result: cover property (@(posedge ref_clk) disable iff (!rst_n) coin_cell_done && meas_reg);

endmodule

// ### tb/pcfe_host.sv
// ****************************************
// Host model issuing single-byte accesses
// ****************************************
module pcfe_host (
  // Clock
  input  wire logic           ref_clk,
  // Register access port
  output pcfe_pkg::pcfe_req_t req,
  input  wire logic [7:0]     rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle request from time zero
  initial req = '0;

  // Write one byte, held for the single taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    req <= '0;
  endtask

  // Key write directly ahead of a protected write
  task automatic pwr(input logic [7:0] a, input logic [7:0] d);
    wr(pcfe_pkg::UNLOCK_KEY_ADDR, pcfe_pkg::UNLOCK_KEY_DEFAULT);
    wr(a, d);
  endtask

  // Read one byte; data is taken in the cycle after the request
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    req <= '0;
    @(negedge ref_clk);
    d = rdata;
  endtask
endmodule

// ### tb/pmic_control_flag_enable_regs_tb.sv
module pmic_control_flag_enable_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signals, clock and instances
  // ****************************************
  logic ref_clk = 1'b0, rst_n = 1'b0, seal = 1'b0, pfo_n = 1'b1, pu = 1'b0, wk = 1'b0, cc_done = 1'b0;
  logic [7:0] kept = 8'h00, key = pcfe_pkg::UNLOCK_KEY_DEFAULT, rdata, d;
  logic [1:0] cc_raw = 2'h0, cc_lvl;
  logic key_written, cc_trig, cc_val, shutdown_req, seen;
  logic [5:0] buck_on;
  pcfe_pkg::pcfe_req_t req;
  pcfe_pkg::pcfe_seq_t seq = '0;
  int mismatches = 0, n_tests = 0;
  localparam logic [7:0] CA = pcfe_pkg::POWER_CONTROL_ADDR, EA = pcfe_pkg::BUCK_RAIL_ENABLES_ADDR;
  localparam logic [7:0] FA = pcfe_pkg::RESUME_FLAGS_ADDR, KA = pcfe_pkg::UNLOCK_KEY_ADDR;

  // Free-running 100 MHz clock
  initial forever #5 ref_clk = ~ref_clk;

  pcfe_host u_host (.ref_clk(ref_clk), .req(req), .rdata(rdata));
  pcfe_regs u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rdata(rdata), .unlock_key_value(key),
    .factory_seal_status(seal), .key_written(key_written), .power_fail_output_n(pfo_n), .seq(seq),
    .power_up_from_off(pu), .wake_from_suspend(wk), .suspend_kept(kept), .coin_cell_done(cc_done),
    .coin_cell_raw(cc_raw), .coin_cell_measure_trigger(cc_trig), .coin_cell_level(cc_lvl),
    .coin_cell_level_valid(cc_val), .buck_on(buck_on), .shutdown_req(shutdown_req));

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    u_host.rd(a, d);
    chk(d, exp);
  endtask
  // One-cycle pulses on event inputs
  task automatic pulse_pu();
    @(posedge ref_clk) pu <= 1'b1;
    @(posedge ref_clk) pu <= 1'b0;
  endtask
  task automatic pulse_wk(input logic [7:0] k);
    @(posedge ref_clk) begin kept <= k; wk <= 1'b1; end
    @(posedge ref_clk) wk <= 1'b0;
  endtask
  // Bounded watch for a flag within n cycles
  task automatic watch(ref logic s, input int n);
    seen = 1'b0;
    repeat (n) @(negedge ref_clk) seen |= (s === 1'b1);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rdchk(CA, 8'h00);
    rdchk(FA, 8'h00);
    rdchk(KA, 8'h00);
    rdchk(EA, 8'h00);
    chk({7'h00, shutdown_req}, 8'h01);
    @(posedge ref_clk) cc_done <= 1'b1;
    @(posedge ref_clk) cc_done <= 1'b0;
    repeat (2) @(negedge ref_clk);
    chk({7'h00, cc_val}, 8'h00);
  endtask
  task automatic t_ctrl();
    pulse_pu();
    u_host.wr(CA, 8'hFF);
    watch(cc_trig, 4);
    chk({7'h00, seen}, 8'h01);
    rdchk(CA, 8'h02);
    u_host.wr(CA, 8'h00);
    rdchk(CA, 8'h00);
  endtask
  task automatic t_pfail();
    @(posedge ref_clk) pfo_n <= 1'b0;
    watch(shutdown_req, 6);
    chk({7'h00, seen}, 8'h00);
    u_host.wr(CA, 8'h02);
    watch(shutdown_req, 6);
    chk({7'h00, seen}, 8'h01);
    @(posedge ref_clk) pfo_n <= 1'b1;
    u_host.wr(CA, 8'h00);
    pulse_pu();
    repeat (2) @(negedge ref_clk);
    chk({7'h00, shutdown_req}, 8'h00);
  endtask
  task automatic t_key();
    u_host.wr(EA, 8'h3F);
    rdchk(EA, 8'h00);
    u_host.pwr(EA, 8'hFF);
    rdchk(EA, 8'h3F);
    chk({2'h0, buck_on}, 8'h3F);
    rdchk(KA, 8'h00);
    u_host.wr(KA, ~key);
    u_host.wr(EA, 8'h00);
    rdchk(EA, 8'h3F);
    u_host.wr(KA, key);
    @(negedge ref_clk);
    chk({7'h00, key_written}, 8'h01);
    u_host.wr(CA, 8'h00);
    @(negedge ref_clk);
    chk({7'h00, key_written}, 8'h00);
    u_host.wr(EA, 8'h00);
    rdchk(EA, 8'h3F);
  endtask
  task automatic t_seal();
    @(posedge ref_clk) seal <= 1'b1;
    u_host.pwr(EA, 8'h00);
    rdchk(EA, 8'h30);
    @(posedge ref_clk) seal <= 1'b0;
    u_host.pwr(EA, 8'h00);
    rdchk(EA, 8'h00);
  endtask
  task automatic t_seq();
    @(posedge ref_clk) seq <= '{buck_on: 4'h9, valid: 1'b1};
    @(posedge ref_clk) seq <= '0;
    rdchk(EA, 8'h09);
  endtask
  task automatic t_flags();
    pulse_wk(8'hA5);
    rdchk(FA, 8'hA5);
    pulse_wk(8'h0F);
    rdchk(FA, 8'h0F);
    pulse_pu();
    rdchk(FA, 8'h00);
  endtask
  task automatic t_coin();
    @(posedge ref_clk) cc_raw <= 2'h2;
    u_host.wr(CA, 8'h01);
    repeat (3) @(negedge ref_clk);
    chk({7'h00, cc_val}, 8'h00);
    @(posedge ref_clk) cc_done <= 1'b1;
    @(posedge ref_clk) cc_done <= 1'b0;
    repeat (2) @(negedge ref_clk);
    chk({5'h00, cc_val, cc_lvl}, 8'h06);
  endtask

  // Report counts and verdict, then stop
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_ctrl();
    t_pfail();
    t_key();
    t_seal();
    t_seq();
    t_flags();
    t_coin();
    end_sim();
  end
endmodule
